// file: ddsl_top.sv
`timescale 1ns/100ps
// Contract
// - Activating bank waits on no-op, turns row-active after row-to-column delay.
// - Write recovery returns bank to active after recovery time; commands meanwhile illegal.
// - Write recovery with autoclose starts closing after recovery time; only no-op allowed.
// - Self refresh holds while clock-enable low; quiet rise exits after exit delay.
// - Power-down holds while clock-enable low; rise returns after input setup time.
// - Clock-enable fall, all idle, quiet command: enter precharge power-down.
// - Clock-enable fall, open row, quiet command: enter active power-down.
// - Self refresh entered only from all idle with refresh encoding on fall.
// - Mode load with all strobes low and banks idle captures twelve address pins.
// - Address bits 0-2 pick burst length: 001 two, 010 four, 011 eight.
// - Address bit 3 picks sequential wrap or interleaved start XOR beat order.
// - Address bits 4-6 pick read latency: 010 two, 011 three, 110 two and half.
// - Test bit stays low; address bit 8 written one resets the DLL.
// - Bank-select 00 loads mode register, 01 extended; bit 1 high is reserved.
// - Extended register address bit 0 low enables the DLL; other pins low.
// - Closing bank waits on no-op and returns to idle after precharge period; the code flags open, read and write there but lets a close pass unflagged.
module ddsl_top
	import ddsl_pkg::*;
#(
	parameter int DLL_LOCK = DLL_LOCK_CLOCKS
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Command pins
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [BANK_W-1:0] ba_i,
	input wire logic [ADDR_W-1:0] addr_i,
	// State
	output logic [3*NUM_BANKS-1:0] bank_state_o,
	output logic [2:0] cmd_state_o,
	output logic active_power_down_o,
	output logic illegal_cmd_o,
	// Mode registers
	output logic [ADDR_W-1:0] mode_reg_o,
	output logic [ADDR_W-1:0] ext_mode_reg_o,
	output logic [3:0] burst_len_o,
	output logic burst_interleave_o,
	output logic [2:0] read_latency_o,
	// DLL
	output logic dll_enable_o,
	output logic dll_reset_o,
	output logic read_ready_o,
	// Burst columns
	output logic burst_active_o,
	output logic [2:0] burst_col_o
);
	localparam int A_RC = ROWCYC_CYC;
	localparam int A_XS = SR_EXIT_CYC;
	localparam int A_IS = SETUP_CYC;
	localparam int A_LOCK = DLL_LOCK;

	logic rst_n;
	logic [PIN_W-1:0] pins_s;
	logic cke_s;
	logic cs_n_s;
	logic ras_n_s;
	logic cas_n_s;
	logic we_n_s;
	logic [BANK_W-1:0] ba_s;
	logic [ADDR_W-1:0] addr_s;
	logic cke_prev_q;
	ddsl_cmd_state_t gs_q;
	ddsl_cmd_state_t gs_d;
	logic [CNT_W-1:0] gcnt_q;
	logic [CNT_W-1:0] gcnt_d;
	logic [ADDR_W-1:0] mode_q;
	logic [ADDR_W-1:0] ext_q;
	logic [3:0] bl_q;
	logic [2:0] lat_q;
	logic dll_en_q;
	logic dll_rst_q;
	logic [LOCK_W-1:0] lock_q;
	logic ready_q;
	logic ill_q;
	logic apd_q;
	logic apd_d;
	logic burst_q;
	logic [2:0] start_q;
	logic [2:0] beat_q;
	logic [2:0] col_q;
	logic cmd;
	logic quiet;
	logic ref_enc;
	logic load_enc;
	logic c_open;
	logic c_rd;
	logic c_wr;
	logic c_close;
	logic c_ref;
	logic c_load;
	logic load_mode;
	logic load_ext;
	logic sr_done;
	logic glob_ill;
	logic busy_ill;
	logic rd_ill;
	logic all_idle;
	logic stable;
	logic any_active;
	logic [NUM_BANKS-1:0] bank_ill;
	ddsl_bank_state_t burst_halt_cmd [NUM_BANKS];

	// Reset release and pin capture
	ddsl_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
		.clk_i(clk_i),
		.rst_n_i(nrst_i),
		.d_i(1'b1),
		.q_o(rst_n)
	);

	ddsl_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_pin_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.d_i({cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i}),
		.q_o(pins_s)
	);

	assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s} = pins_s;

	// Command decode
	assign cmd = cke_prev_q & cke_s & !cs_n_s & (gs_q == GS_RUN);
	assign quiet = cs_n_s | (ras_n_s & cas_n_s);
	assign ref_enc = !cs_n_s & !ras_n_s & !cas_n_s & we_n_s;
	assign load_enc = !cs_n_s & !ras_n_s & !cas_n_s & !we_n_s;
	assign c_open = cmd & !ras_n_s & cas_n_s & we_n_s;
	assign c_close = cmd & !ras_n_s & cas_n_s & !we_n_s;
	assign c_rd = cmd & ras_n_s & !cas_n_s & we_n_s;
	assign c_wr = cmd & ras_n_s & !cas_n_s & !we_n_s;
	assign c_ref = cmd & ref_enc;
	assign c_load = cmd & load_enc;
	assign rd_ill = c_rd & !ready_q;
	assign busy_ill = cke_s & !quiet & (gs_q == GS_REFRESH || gs_q == GS_MODE
		|| gs_q == GS_SR_EXIT || gs_q == GS_PD_EXIT);

	// Bank machines
	for (genvar i = 0; i < NUM_BANKS; i++)
	begin : g_bank
		ddsl_bank u_bank (
			.clk_i(clk_i),
			.rst_n_i(rst_n),
			.open_i(c_open && ba_s == BANK_W'(i)),
			.rd_i(c_rd && ba_s == BANK_W'(i)),
			.wr_i(c_wr && ba_s == BANK_W'(i)),
			.close_i(c_close && (addr_s[AUTOCLOSE_BIT] || ba_s == BANK_W'(i))),
			.ac_i(addr_s[AUTOCLOSE_BIT]),
			.state_o(burst_halt_cmd[i]),
			.illegal_o(bank_ill[i])
		);
		assign bank_state_o[3*i +: 3] = burst_halt_cmd[i];
	end

	always_comb
	begin
		all_idle = 1'b1;
		stable = 1'b1;
		any_active = 1'b0;
		for (int b = 0; b < NUM_BANKS; b++)
		begin
			all_idle = all_idle & (burst_halt_cmd[b] == BK_IDLE);
			stable = stable & (burst_halt_cmd[b] == BK_IDLE || burst_halt_cmd[b] == BK_ACTIVE);
			any_active = any_active | (burst_halt_cmd[b] == BK_ACTIVE);
		end
	end

	// Clock-enable and global command machine
	always_comb
	begin
		gs_d = gs_q;
		gcnt_d = (gcnt_q != '0) ? gcnt_q - 1'b1 : gcnt_q;
		apd_d = apd_q;
		glob_ill = 1'b0;
		load_mode = 1'b0;
		load_ext = 1'b0;
		sr_done = 1'b0;
		case (gs_q)
			GS_RUN:
				if (!cke_s)
				begin
					if (cke_prev_q && ref_enc)
					begin
						if (all_idle)
							gs_d = GS_SELF;
						else
							glob_ill = 1'b1;
					end
					else if ((quiet || !cke_prev_q) && stable)
					begin
						gs_d = GS_PDOWN;
						apd_d = any_active;
					end
					else
						glob_ill = 1'b1;
				end
				else if (c_ref)
				begin
					if (all_idle)
					begin
						gs_d = GS_REFRESH;
						gcnt_d = CNT_W'(ROWCYC_CYC - 1);
					end
					else
						glob_ill = 1'b1;
				end
				else if (c_load)
				begin
					if (all_idle && !ba_s[1])
					begin
						gs_d = GS_MODE;
						gcnt_d = CNT_W'(MODE_LOAD_CLOCKS - 1);
						load_mode = (ba_s == TGT_MODE);
						load_ext = (ba_s == TGT_EXT);
					end
					else
						glob_ill = 1'b1;
				end
			GS_REFRESH, GS_MODE, GS_SR_EXIT, GS_PD_EXIT:
				if (gcnt_q == '0)
					gs_d = GS_RUN;
			GS_PDOWN:
				if (cke_s)
				begin
					gs_d = GS_PD_EXIT;
					gcnt_d = CNT_W'(SETUP_CYC - 1);
				end
			GS_SELF:
				if (cke_s)
				begin
					if (quiet)
					begin
						gs_d = GS_SR_EXIT;
						gcnt_d = CNT_W'(SR_EXIT_CYC - 1);
						sr_done = 1'b1;
					end
					else
						glob_ill = 1'b1;
				end
			default: gs_d = GS_RUN;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gs_q <= GS_RUN;
			gcnt_q <= '0;
			cke_prev_q <= 1'b0;
			apd_q <= 1'b0;
			ill_q <= 1'b0;
		end
		else
		begin
			gs_q <= gs_d;
			gcnt_q <= gcnt_d;
			cke_prev_q <= cke_s;
			apd_q <= apd_d;
			ill_q <= (|bank_ill) | glob_ill | busy_ill | rd_ill;
		end
	end

	// Mode registers
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q <= MODE_RST;
			ext_q <= EXT_RST;
			bl_q <= 4'h0;
			lat_q <= 3'h0;
			dll_en_q <= 1'b0;
		end
		else
		begin
			if (load_mode)
			begin
				mode_q <= addr_s;
				bl_q <= bl_decode(addr_s[BL_LSB +: 3]);
				lat_q <= lat_decode(addr_s[LAT_LSB +: 3]);
			end
			if (load_ext)
			begin
				ext_q <= addr_s;
				dll_en_q <= !addr_s[DLL_EN_BIT];
			end
		end
	end

	// DLL reset and lock wait
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dll_rst_q <= 1'b0;
			lock_q <= '0;
			ready_q <= 1'b0;
		end
		else
		begin
			dll_rst_q <= load_mode & addr_s[DLL_RST_BIT];
			if ((load_mode && addr_s[DLL_RST_BIT]) || (load_ext && !addr_s[DLL_EN_BIT]) || sr_done)
				lock_q <= LOCK_W'(DLL_LOCK);
			else if (lock_q != '0)
				lock_q <= lock_q - 1'b1;
			ready_q <= dll_en_q && (lock_q == '0);
		end
	end

	// Burst column sequencing
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			burst_q <= 1'b0;
			start_q <= 3'h0;
			beat_q <= 3'h0;
			col_q <= 3'h0;
		end
		else if ((c_rd || c_wr) && burst_halt_cmd[ba_s] == BK_ACTIVE && bl_q != 4'h0)
		begin
			burst_q <= 1'b1;
			start_q <= addr_s[2:0];
			beat_q <= 3'h0;
			col_q <= addr_s[2:0];
		end
		else if (burst_q)
		begin
			if ({1'b0, beat_q} == bl_q - 4'h1)
				burst_q <= 1'b0;
			beat_q <= beat_q + 3'h1;
			col_q <= burst_col(start_q, beat_q + 3'h1, bl_q, mode_q[ORDER_BIT]);
		end
	end

	assign cmd_state_o = gs_q;
	assign active_power_down_o = apd_q;
	assign illegal_cmd_o = ill_q;
	assign mode_reg_o = mode_q;
	assign ext_mode_reg_o = ext_q;
	assign burst_len_o = bl_q;
	assign burst_interleave_o = mode_q[ORDER_BIT];
	assign read_latency_o = lat_q;
	assign dll_enable_o = dll_en_q;
	assign dll_reset_o = dll_rst_q;
	assign read_ready_o = ready_q;
	assign burst_active_o = burst_q;
	assign burst_col_o = col_q;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	sequence s_load_cycle;
		gs_q == GS_RUN && cke_prev_q && cke_s && load_enc && all_idle;
	endsequence
	sequence s_quiet_fall;
		gs_q == GS_RUN && cke_prev_q && !cke_s && quiet && stable;
	endsequence

	chk_self_hold: assert property (
		(gs_q == GS_SELF && !cke_s) |=> gs_q == GS_SELF)
		else $error("self refresh left while clock-enable low");
	chk_self_exit: assert property (
		(gs_q == GS_SELF && cke_s && quiet) |=> (gs_q == GS_SR_EXIT) ##A_XS (gs_q == GS_RUN))
		else $error("self refresh exit delay wrong");
	chk_pd_exit: assert property (
		(gs_q == GS_PDOWN && cke_s) |=> (gs_q == GS_PD_EXIT) ##A_IS (gs_q == GS_RUN))
		else $error("power-down exit timing wrong");
	chk_pd_idle: assert property (
		(s_quiet_fall ##0 all_idle) |=> gs_q == GS_PDOWN && !apd_q)
		else $error("precharge power-down not entered");
	chk_pd_active: assert property (
		(s_quiet_fall ##0 any_active) |=> gs_q == GS_PDOWN && apd_q)
		else $error("active power-down not entered");
	chk_self_entry: assert property (
		(gs_q == GS_SELF && $past(gs_q) == GS_RUN) |-> $past(all_idle) && $past(ref_enc))
		else $error("self refresh entered without all banks idle");
	chk_mode_capture: assert property (
		(s_load_cycle ##0 ba_s == TGT_MODE) |=> mode_q == $past(addr_s) && gs_q == GS_MODE)
		else $error("mode register load not captured");
	chk_burst_length: assert property (
		bl_q == (mode_q[2:0] == 3'h1 ? 4'h2 : mode_q[2:0] == 3'h2 ? 4'h4
			: mode_q[2:0] == 3'h3 ? 4'h8 : 4'h0))
		else $error("burst length decode wrong");
	chk_burst_order: assert property (
		(burst_q && bl_q == 4'h8) |-> col_q == (mode_q[ORDER_BIT] ? (start_q ^ beat_q)
			: 3'(start_q + beat_q)))
		else $error("burst column order wrong");
	chk_latency_code: assert property (
		lat_q == (mode_q[6:4] == 3'h2 ? 3'h4 : mode_q[6:4] == 3'h3 ? 3'h6
			: mode_q[6:4] == 3'h6 ? 3'h5 : 3'h0))
		else $error("read latency decode wrong");
	chk_dll_reset: assert property (
		(s_load_cycle ##0 (ba_s == TGT_MODE && addr_s[DLL_RST_BIT]))
		|=> dll_reset_o && lock_q == LOCK_W'(A_LOCK) ##1 !dll_reset_o)
		else $error("DLL reset not applied");
	chk_ext_target: assert property (
		(s_load_cycle ##0 ba_s == TGT_EXT) |=> ext_q == $past(addr_s) && mode_q == $past(mode_q))
		else $error("extended register load went astray");
	chk_reserved_target: assert property (
		(s_load_cycle ##0 ba_s[1]) |=> ill_q && mode_q == $past(mode_q) && gs_q == GS_RUN)
		else $error("reserved load target not refused");
	chk_dll_enable: assert property (
		(s_load_cycle ##0 ba_s == TGT_EXT) |=> dll_en_q == !$past(addr_s[DLL_EN_BIT]))
		else $error("DLL enable bit not applied");
	chk_refresh_time: assert property (
		(gs_q == GS_RUN && cke_prev_q && cke_s && ref_enc && all_idle)
		|=> (gs_q == GS_REFRESH) ##A_RC (gs_q == GS_RUN))
		else $error("auto refresh duration wrong");
endmodule // ddsl_top

// file: ddsl_pkg.sv
package ddsl_pkg;

	// Clock and timing figures
	localparam int CLK_PERIOD_PS = 20000;
	localparam int ROW_TO_COLUMN_DELAY_PS = 15000;
	localparam int WRITE_RECOVERY_TIME_PS = 15000;
	localparam int PRECHARGE_PERIOD_PS = 15000;
	localparam int ROW_CYCLE_TIME_PS = 50000;
	localparam int SELF_REFRESH_EXIT_DELAY_PS = 75000;
	localparam int INPUT_SETUP_TIME_PS = 600;
	localparam int MODE_LOAD_CLOCKS = 2;
	localparam int DLL_LOCK_CLOCKS = 200;

	// Least times rounded up to whole cycles
	localparam int ROW_COL_CYC = (ROW_TO_COLUMN_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WREC_CYC = (WRITE_RECOVERY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CLOSE_CYC = (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ROWCYC_CYC = (ROW_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SR_EXIT_CYC = (SELF_REFRESH_EXIT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETUP_CYC = (INPUT_SETUP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Widths
	localparam int CNT_W = 3;
	localparam int LOCK_W = 8;
	localparam int ADDR_W = 12;
	localparam int BANK_W = 2;
	localparam int NUM_BANKS = 4;
	localparam int PIN_W = 19;
	localparam logic [18:0] PIN_RST = 19'h3C000;

	// Register fields and reset values
	localparam int BL_LSB = 0;
	localparam int ORDER_BIT = 3;
	localparam int LAT_LSB = 4;
	localparam int DLL_RST_BIT = 8;
	localparam int DLL_EN_BIT = 0;
	localparam int AUTOCLOSE_BIT = 10;
	localparam logic [11:0] MODE_RST = 12'h000;
	localparam logic [11:0] EXT_RST = 12'h000;
	localparam logic [1:0] TGT_MODE = 2'h0;
	localparam logic [1:0] TGT_EXT = 2'h1;

	typedef enum logic [2:0] {
		BK_IDLE = 3'h0, BK_ACTIVATING = 3'h1, BK_ACTIVE = 3'h3,
		BK_WREC = 3'h2, BK_WREC_AC = 3'h6, BK_CLOSING = 3'h7
	} ddsl_bank_state_t;

	typedef enum logic [2:0] {
		GS_RUN = 3'h0, GS_REFRESH = 3'h1, GS_MODE = 3'h3, GS_PDOWN = 3'h2,
		GS_SELF = 3'h6, GS_SR_EXIT = 3'h7, GS_PD_EXIT = 3'h5
	} ddsl_cmd_state_t;

	function automatic logic [3:0] bl_decode(input logic [2:0] code);
		case (code)
			3'h1: return 4'h2;
			3'h2: return 4'h4;
			3'h3: return 4'h8;
			default: return 4'h0;
		endcase
	endfunction

	// Latency in half clocks
	function automatic logic [2:0] lat_decode(input logic [2:0] code);
		case (code)
			3'h2: return 3'h4;
			3'h3: return 3'h6;
			3'h6: return 3'h5;
			default: return 3'h0;
		endcase
	endfunction

	function automatic logic [2:0] burst_col(input logic [2:0] start, input logic [2:0] beat,
		input logic [3:0] len, input logic ilv);
		logic [2:0] mask;
		logic [2:0] off;
		mask = 3'(len - 4'h1);
		off = ilv ? (start ^ beat) : 3'(start + beat);
		return (start & ~mask) | (off & mask);
	endfunction

endpackage

// file: ddsl_sync.sv
`timescale 1ns/100ps
module ddsl_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= RST_VAL;
			q_o <= RST_VAL;
		end
		else
		begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule // ddsl_sync

// file: ddsl_bank.sv
`timescale 1ns/100ps
module ddsl_bank
	import ddsl_pkg::*;
#(
	parameter int RC_CYC = ROW_COL_CYC,
	parameter int WR_CYC = WREC_CYC,
	parameter int RP_CYC = CLOSE_CYC
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Commands aimed at this bank
	input wire logic open_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic close_i,
	input wire logic ac_i,
	// State
	output ddsl_bank_state_t state_o,
	output logic illegal_o
);
	localparam int A_RC = RC_CYC;
	localparam int A_WR = WR_CYC;
	localparam int A_RP = RP_CYC;

	ddsl_bank_state_t state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic any_cmd;

	assign any_cmd = open_i | rd_i | wr_i | close_i;

	always_comb
	begin
		state_d = state_o;
		cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
		illegal_o = 1'b0;
		case (state_o)
			BK_IDLE:
				if (open_i)
				begin
					state_d = BK_ACTIVATING;
					cnt_d = CNT_W'(RC_CYC - 1);
				end
				else if (rd_i | wr_i)
					illegal_o = 1'b1;
			BK_ACTIVATING:
			begin
				illegal_o = any_cmd;
				if (cnt_q == '0)
					state_d = BK_ACTIVE;
			end
			BK_ACTIVE:
				if (open_i)
					illegal_o = 1'b1;
				else if (close_i | (rd_i & ac_i))
				begin
					state_d = BK_CLOSING;
					cnt_d = CNT_W'(RP_CYC - 1);
				end
				else if (wr_i)
				begin
					state_d = ac_i ? BK_WREC_AC : BK_WREC;
					cnt_d = CNT_W'(WR_CYC - 1);
				end
			BK_WREC:
			begin
				illegal_o = any_cmd;
				if (cnt_q == '0)
					state_d = BK_ACTIVE;
			end
			BK_WREC_AC:
			begin
				illegal_o = any_cmd;
				if (cnt_q == '0)
				begin
					state_d = BK_CLOSING;
					cnt_d = CNT_W'(RP_CYC - 1);
				end
			end
			BK_CLOSING:
			begin
				illegal_o = open_i | rd_i | wr_i;
				if (cnt_q == '0)
					state_d = BK_IDLE;
			end
			default: state_d = BK_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_o <= BK_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			state_o <= state_d;
			cnt_q <= cnt_d;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	chk_activate_wait: assert property (
		(state_o == BK_IDLE && open_i) |=> (state_o == BK_ACTIVATING) ##A_RC (state_o == BK_ACTIVE))
		else $error("row open did not become active after the delay");
	chk_recovery_return: assert property (
		(state_o == BK_ACTIVE && wr_i && !ac_i && !open_i && !close_i)
		|=> (state_o == BK_WREC) ##A_WR (state_o == BK_ACTIVE))
		else $error("write recovery did not return to active");
	chk_recovery_guard: assert property (
		(state_o == BK_WREC && any_cmd) |-> illegal_o ##1 (state_o != BK_IDLE))
		else $error("command during write recovery not flagged");
	chk_autoclose_write: assert property (
		(state_o == BK_ACTIVE && wr_i && ac_i && !open_i && !close_i)
		|=> (state_o == BK_WREC_AC) ##A_WR (state_o == BK_CLOSING))
		else $error("autoclose write did not start closing");
	chk_close_idle: assert property (
		(state_o == BK_ACTIVE && close_i && !open_i)
		|=> (state_o == BK_CLOSING) ##A_RP (state_o == BK_IDLE))
		else $error("closing bank did not return to idle");
endmodule // ddsl_bank

// file: ddsl_ctrl_model.sv
`timescale 1ns/100ps
module ddsl_ctrl_model
	import ddsl_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Command pins
	output logic cke_o,
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic [BANK_W-1:0] ba_o,
	output logic [ADDR_W-1:0] addr_o
);
	initial
	begin
		cke_o = 1'b1;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
		ba_o = 2'h0;
		addr_o = 12'h000;
	end

	// One command cycle, then no-op with stale lines inverted
	task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [11:0] a,
		input logic ck);
		@(negedge clk_i);
		cke_o = ck;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = c;
		ba_o = ba;
		addr_o = a;
		@(negedge clk_i);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
		ba_o = ~ba;
		addr_o = ~a;
	endtask
endmodule // ddsl_ctrl_model

// file: ddsl_tb_top.sv
`timescale 1ns/100ps
module ddsl_tb_top
	import ddsl_pkg::*;
;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic cke, cs_n, ras_n, cas_n, we_n;
	logic [1:0] ba;
	logic [11:0] addr, mode_reg, ext_reg, last_mode, a, ra;
	logic [11:0] bank_state;
	logic [2:0] cmd_state, rd_lat, bcol;
	logic [3:0] blen;
	logic apd, ill, ilv, dll_en, dll_rst, rd_rdy, bact;
	logic [11:0] exp_q[$];
	int err_count = 0;
	int checks = 0;
	int seed = 32'hce8f;
	int i;
	logic [11:0] tbl[4] = '{12'h021, 12'h060, 12'h032, 12'h063};
	logic [3:0] bl_e[4] = '{4'h2, 4'h0, 4'h4, 4'h8};
	logic [2:0] lat_e[4] = '{3'h4, 3'h5, 3'h6, 3'h5};

	always #10 clk_i = ~clk_i;

	ddsl_ctrl_model m (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
		.cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr));

	ddsl_top #(.DLL_LOCK(8)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .cke_i(cke),
		.cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba),
		.addr_i(addr), .bank_state_o(bank_state), .cmd_state_o(cmd_state),
		.active_power_down_o(apd), .illegal_cmd_o(ill), .mode_reg_o(mode_reg),
		.ext_mode_reg_o(ext_reg), .burst_len_o(blen), .burst_interleave_o(ilv),
		.read_latency_o(rd_lat), .dll_enable_o(dll_en), .dll_reset_o(dll_rst),
		.read_ready_o(rd_rdy), .burst_active_o(bact), .burst_col_o(bcol));

	task automatic cmp_reg(input string n, input logic [11:0] e, input logic [11:0] g);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cmp_state(input string n, input logic [2:0] e, input logic [2:0] g);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic complete_run();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Mode register watcher against driver notes
	initial last_mode = 12'h000;
	always @(posedge clk_i)
	begin
		#1;
		if (nrst_i && mode_reg !== last_mode)
		begin
			last_mode = mode_reg;
			if (exp_q.size() == 0)
				cmp_reg("mode_reg unexpected", last_mode, 12'hFFF);
			else
				cmp_reg("mode_reg", exp_q.pop_front(), mode_reg);
		end
	end

	initial
	begin
		repeat (8) @(negedge clk_i);
		nrst_i = 1'b1;
		wt(4);
		m.cmd(4'h0, 2'h1, 12'h000, 1'b1);
		wt(3);
		cmp_reg("dll_enable", 12'h001, {11'h0, dll_en});
		cmp_reg("read_ready", 12'h000, {11'h0, rd_rdy});
		cmp_reg("ext_reg", 12'h000, ext_reg);
		wt(3);
		exp_q.push_back(12'h132);
		m.cmd(4'h0, 2'h0, 12'h132, 1'b1);
		wt(2);
		cmp_reg("dll_reset", 12'h001, {11'h0, dll_rst});
		cmp_state("cmd_state", 3'h3, cmd_state);
		cmp_reg("burst_len", 12'h004, {8'h0, blen});
		cmp_state("latency", 3'h6, rd_lat);
		wt(1);
		cmp_reg("dll_reset", 12'h000, {11'h0, dll_rst});
		wt(1);
		cmp_state("cmd_state", 3'h0, cmd_state);
		for (i = 0; i < 300 && rd_rdy !== 1'b1; i++)
			@(negedge clk_i);
		cmp_reg("read_ready", 12'h001, {11'h0, rd_rdy});
		if (rd_rdy !== 1'b1)
			complete_run();
		a = 12'($random(seed));
		m.cmd(4'h3, 2'h1, a, 1'b1);
		wt(2);
		cmp_state("bank1", 3'h1, bank_state[5:3]);
		wt(1);
		cmp_state("bank1", 3'h3, bank_state[5:3]);
		m.cmd(4'h1, 2'h0, 12'h000, 1'b1);
		wt(2);
		cmp_reg("illegal", 12'h001, {11'h0, ill});
		m.cmd(4'h7, 2'h0, 12'h000, 1'b0);
		wt(3);
		cmp_state("cmd_state", 3'h2, cmd_state);
		cmp_reg("apd", 12'h001, {11'h0, apd});
		m.cmd(4'h7, 2'h0, 12'h000, 1'b1);
		wt(2);
		cmp_state("cmd_state", 3'h5, cmd_state);
		wt(1);
		cmp_state("cmd_state", 3'h0, cmd_state);
		m.cmd(4'h4, 2'h1, 12'h000, 1'b1);
		wt(2);
		cmp_state("bank1", 3'h2, bank_state[5:3]);
		wt(1);
		cmp_state("bank1", 3'h3, bank_state[5:3]);
		m.cmd(4'h4, 2'h1, 12'h400, 1'b1);
		wt(2);
		cmp_state("bank1", 3'h6, bank_state[5:3]);
		wt(1);
		cmp_state("bank1", 3'h7, bank_state[5:3]);
		wt(1);
		cmp_state("bank1", 3'h0, bank_state[5:3]);
		m.cmd(4'h1, 2'h0, 12'h000, 1'b1);
		wt(3);
		cmp_state("cmd_state", 3'h1, cmd_state);
		wt(3);
		cmp_state("cmd_state", 3'h0, cmd_state);
		m.cmd(4'h7, 2'h0, 12'h000, 1'b0);
		wt(3);
		cmp_state("cmd_state", 3'h2, cmd_state);
		cmp_reg("apd", 12'h000, {11'h0, apd});
		m.cmd(4'h7, 2'h0, 12'h000, 1'b1);
		wt(4);
		m.cmd(4'h1, 2'h0, 12'h000, 1'b0);
		wt(3);
		cmp_state("cmd_state", 3'h6, cmd_state);
		wt(5);
		cmp_state("cmd_state", 3'h6, cmd_state);
		m.cmd(4'hF, 2'h0, 12'h000, 1'b1);
		wt(3);
		cmp_state("cmd_state", 3'h7, cmd_state);
		wt(4);
		cmp_state("cmd_state", 3'h0, cmd_state);
		m.cmd(4'h0, 2'h2, 12'h0FF, 1'b1);
		wt(2);
		cmp_reg("illegal", 12'h001, {11'h0, ill});
		wt(3);
		for (int k = 0; k < 4; k++)
		begin
			a = tbl[k] | {8'h0, 1'($random(seed)), 3'h0};
			exp_q.push_back(a);
			m.cmd(4'h0, 2'h0, a, 1'b1);
			wt(3);
			cmp_reg("burst_len", {8'h0, bl_e[k]}, {8'h0, blen});
			cmp_state("latency", lat_e[k], rd_lat);
			cmp_reg("interleave", {11'h0, a[3]}, {11'h0, ilv});
			wt(3);
		end
		wt(4);
		m.cmd(4'h3, 2'h2, 12'h0A5, 1'b1);
		wt(3);
		ra = 12'($random(seed)) & 12'h3FF;
		m.cmd(4'h5, 2'h2, ra, 1'b1);
		wt(2);
		cmp_reg("illegal", 12'h000, {11'h0, ill});
		cmp_reg("burst_active", 12'h001, {11'h0, bact});
		cmp_state("burst_col", ra[2:0], bcol);
		wt(1);
		cmp_state("burst_col", a[3] ? (ra[2:0] ^ 3'h1) : 3'(ra[2:0] + 3'h1), bcol);
		m.cmd(4'h2, 2'h2, 12'h000, 1'b1);
		wt(2);
		cmp_state("bank2", 3'h7, bank_state[8:6]);
		wt(1);
		cmp_state("bank2", 3'h0, bank_state[8:6]);
		wt(4);
		cmp_reg("pending notes", 12'h000, 12'(exp_q.size()));
		complete_run();
	end
endmodule // ddsl_tb_top
